// >>> rtl/sld_driver.sv
// segment display driver: apb registers, display ram, common/segment scan
// assumes apb master on pclk, sub_clk pin asynchronous to pclk,
// output rail codes decoded by an analog level switch outside
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sld_driver #(
  parameter int NUM_SEG = 32,
  parameter int NUM_COM = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_clk,
  output logic [2*NUM_SEG-1:0] segment_out,
  output logic [2*NUM_COM-1:0] common_out,
  output logic pump_clk,
  output logic [2:0] pll_mult_sel,
  output logic [9:0] pll_mult_x4,
  output logic idle_mode,
  output logic cpu_clock_select
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_SEG != 32 || NUM_COM != 4) begin : g_bad_size
    $error("sld_driver serves 32 segments and 4 commons only");
  end

  // ---------------------------------------------------------------
  // registers and storage
  // ---------------------------------------------------------------
  logic [7:0] display_control;
  logic [4:0] ram_addr;
  logic [7:0] system_booster_pll_control;
  logic [3:0] ram [NUM_SEG];
  logic [3:0] shown [NUM_SEG];
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] next_prdata;

  assign access = psel & penable;
  assign wr = access & pready & pwrite;
  assign mapped = (paddr == sld_pkg::OFS_CONTROL) || (paddr == sld_pkg::OFS_RAM_ADDRESS) ||
                  (paddr == sld_pkg::OFS_RAM_DATA) || (paddr == sld_pkg::OFS_SYS_CONTROL);

  // one wait state: pready rises the cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pready <= 1'b0;
    else pready <= access & ~pready;
  end

  // unmapped offsets answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pslverr <= 1'b0;
    else pslverr <= access & ~pready & ~mapped;
  end

  // control register, bit 3 kept zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) display_control <= sld_pkg::RST_CONTROL;
    else if (wr && paddr == sld_pkg::OFS_CONTROL)
      display_control <= pwdata[7:0] & sld_pkg::CONTROL_MASK;
  end

  // ram address, five bits only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ram_addr <= sld_pkg::RST_RAM_ADDRESS[4:0];
    else if (wr && paddr == sld_pkg::OFS_RAM_ADDRESS)
      ram_addr <= pwdata[4:0];
  end

  // system, booster and pll control, bit 7 kept zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) system_booster_pll_control <= sld_pkg::RST_SYS_CONTROL;
    else if (wr && paddr == sld_pkg::OFS_SYS_CONTROL)
      system_booster_pll_control <= pwdata[7:0] & sld_pkg::SYS_CONTROL_MASK;
  end

  // display ram written only through the data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SEG; i++) ram[i] <= 4'h0;
    end else if (wr && paddr == sld_pkg::OFS_RAM_DATA) begin
      ram[ram_addr] <= pwdata[3:0];
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0;
    case (paddr)
      sld_pkg::OFS_CONTROL: next_prdata[7:0] = display_control;
      sld_pkg::OFS_RAM_ADDRESS: next_prdata[4:0] = ram_addr;
      sld_pkg::OFS_RAM_DATA: next_prdata[3:0] = ram[ram_addr];
      sld_pkg::OFS_SYS_CONTROL: next_prdata[7:0] = system_booster_pll_control;
      default: next_prdata = 32'h0;
    endcase
  end

  // read data captured in the first access cycle, shown with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (access && !pready && !pwrite) prdata <= next_prdata;
  end

  // ---------------------------------------------------------------
  // sub-clock sampling
  // ---------------------------------------------------------------
  logic sub_level;
  logic sub_prev;
  logic sub_rise;

  sld_sync u_sub_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(sub_clk),
    .q(sub_level)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sub_prev <= 1'b0;
    else sub_prev <= sub_level;
  end
  assign sub_rise = sub_level & ~sub_prev;

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  logic enable;
  logic third_bias;
  logic wave_b;
  logic [1:0] frame_code;
  logic [1:0] last_com;
  logic [8:0] slot_len;

  assign enable = display_control[sld_pkg::BIT_DISPLAY_ENABLE];
  assign third_bias = display_control[sld_pkg::BIT_BIAS_SELECT];
  assign wave_b = display_control[sld_pkg::BIT_WAVEFORM_TYPE];
  assign frame_code = display_control[sld_pkg::BIT_FRAME_RATE_HI:sld_pkg::BIT_FRAME_RATE_LO];

  // duty sets the highest common index scanned
  always_comb begin
    if (display_control[sld_pkg::BIT_DUTY_SELECT_HI]) last_com = 2'h3;
    else if (display_control[sld_pkg::BIT_DUTY_SELECT_LO]) last_com = 2'h2;
    else last_com = 2'h1;
  end

  // sub-clock cycles per common slot
  always_comb begin
    case ({last_com, frame_code})
      4'h4: slot_len = sld_pkg::SLOT_HALF_0;
      4'h5: slot_len = sld_pkg::SLOT_HALF_1;
      4'h6: slot_len = sld_pkg::SLOT_HALF_2;
      4'h7: slot_len = sld_pkg::SLOT_HALF_3;
      4'h8: slot_len = sld_pkg::SLOT_THIRD_0;
      4'h9: slot_len = sld_pkg::SLOT_THIRD_1;
      4'ha: slot_len = sld_pkg::SLOT_THIRD_2;
      4'hb: slot_len = sld_pkg::SLOT_THIRD_3;
      4'hc: slot_len = sld_pkg::SLOT_QUARTER_0;
      4'hd: slot_len = sld_pkg::SLOT_QUARTER_1;
      4'he: slot_len = sld_pkg::SLOT_QUARTER_2;
      4'hf: slot_len = sld_pkg::SLOT_QUARTER_3;
      default: slot_len = sld_pkg::SLOT_HALF_0;
    endcase
  end

  // ---------------------------------------------------------------
  // scan timing
  // ---------------------------------------------------------------
  logic [8:0] slot_cnt;
  logic [1:0] com_idx;
  logic frame_pol;
  logic slot_end;
  logic frame_end;
  logic pol;

  assign slot_end = sub_rise && (slot_cnt >= slot_len - 9'h1);
  assign frame_end = slot_end && (com_idx >= last_com);

  // cycle count within one common slot; idle bit is not consulted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) slot_cnt <= 9'h0;
    else if (!enable) slot_cnt <= 9'h0;
    else if (slot_end) slot_cnt <= 9'h0;
    else if (sub_rise) slot_cnt <= slot_cnt + 9'h1;
  end

  // active common steps through the duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) com_idx <= 2'h0;
    else if (!enable) com_idx <= 2'h0;
    else if (frame_end) com_idx <= 2'h0;
    else if (slot_end) com_idx <= com_idx + 2'h1;
  end

  // b-type polarity flips once per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) frame_pol <= 1'b0;
    else if (!enable) frame_pol <= 1'b0;
    else if (frame_end) frame_pol <= ~frame_pol;
  end

  // a-type flips halfway through each slot
  assign pol = wave_b ? frame_pol : (slot_cnt >= {1'b0, slot_len[8:1]});

  // frame snapshot of ram, loaded at enable and at each frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SEG; i++) shown[i] <= 4'h0;
    end else if (!enable || frame_end) begin
      for (int i = 0; i < NUM_SEG; i++) shown[i] <= ram[i];
    end
  end

  // ---------------------------------------------------------------
  // drive levels
  // ---------------------------------------------------------------
  logic [2*NUM_SEG-1:0] next_seg;
  logic [2*NUM_COM-1:0] next_com;
  logic [1:0] sel_lvl;
  logic [1:0] unsel_lvl;
  logic [1:0] on_lvl;
  logic [1:0] off_lvl;

  // rail per role: half bias uses the single middle rail
  always_comb begin
    sel_lvl = pol ? sld_pkg::RAIL_GND : sld_pkg::RAIL_TOP;
    on_lvl = pol ? sld_pkg::RAIL_TOP : sld_pkg::RAIL_GND;
    if (third_bias) begin
      unsel_lvl = pol ? sld_pkg::RAIL_HIGH : sld_pkg::RAIL_LOW;
      off_lvl = pol ? sld_pkg::RAIL_LOW : sld_pkg::RAIL_HIGH;
    end else begin
      unsel_lvl = sld_pkg::RAIL_LOW;
      off_lvl = sld_pkg::RAIL_LOW;
    end
  end

  // commons: selected or unselected, ground when disabled; commons past the duty stay unselected
  always_comb begin
    next_com = '0;
    for (int c = 0; c < NUM_COM; c++) begin
      if (!enable) next_com[2*c +: 2] = sld_pkg::RAIL_GND;
      else if (c[1:0] == com_idx) next_com[2*c +: 2] = sel_lvl;
      else next_com[2*c +: 2] = unsel_lvl;
    end
  end

  // segment n follows ram word n, bit of active common
  always_comb begin
    next_seg = '0;
    for (int s = 0; s < NUM_SEG; s++) begin
      if (!enable) next_seg[2*s +: 2] = sld_pkg::RAIL_GND;
      else if (shown[s][com_idx]) next_seg[2*s +: 2] = on_lvl;
      else next_seg[2*s +: 2] = off_lvl;
    end
  end

  // registered pins, one cycle behind the scan state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment_out <= '0;
      common_out <= '0;
    end else begin
      segment_out <= next_seg;
      common_out <= next_com;
    end
  end

  // ---------------------------------------------------------------
  // system outputs and charge pump
  // ---------------------------------------------------------------
  logic [9:0] next_pll;
  logic [2:0] pll_code;
  logic [1:0] pump_sel;

  assign pll_code = system_booster_pll_control[sld_pkg::BIT_PLL_SEL_HI:sld_pkg::BIT_PLL_SEL_LO];
  assign pump_sel = system_booster_pll_control[sld_pkg::BIT_BOOSTER_HI:sld_pkg::BIT_BOOSTER_LO];

  // top select bit overrides the four low codes
  always_comb begin
    if (pll_code[2]) begin
      next_pll = sld_pkg::PLL_X4_HI;
    end else begin
      case (pll_code[1:0])
        2'h0: next_pll = sld_pkg::PLL_X4_0;
        2'h1: next_pll = sld_pkg::PLL_X4_1;
        2'h2: next_pll = sld_pkg::PLL_X4_2;
        2'h3: next_pll = sld_pkg::PLL_X4_3;
        default: next_pll = sld_pkg::PLL_X4_0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_mult_sel <= 3'h0;
      pll_mult_x4 <= sld_pkg::PLL_X4_0;
      idle_mode <= 1'b0;
      cpu_clock_select <= 1'b0;
    end else begin
      pll_mult_sel <= pll_code;
      pll_mult_x4 <= next_pll;
      idle_mode <= system_booster_pll_control[sld_pkg::BIT_IDLE];
      cpu_clock_select <= system_booster_pll_control[sld_pkg::BIT_CPU_CLOCK_SELECT];
    end
  end

  sld_booster u_booster (
    .pclk(pclk),
    .presetn(presetn),
    .sub_level(sub_level),
    .sub_rise(sub_rise),
    .freq_sel(pump_sel),
    .pump_clk(pump_clk)
  );
endmodule : sld_driver
`default_nettype wire

// >>> rtl/sld_pkg.sv
// segment display driver: shared constants
// assumes a 32-bit apb slave port, a sub-clock pin and a 100 MHz pclk
package sld_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RAM_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_RAM_DATA = 8'h08;
  localparam logic [7:0] OFS_SYS_CONTROL = 8'h0c;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int BIT_BIAS_SELECT = 7;
  localparam int BIT_DUTY_SELECT_HI = 6;
  localparam int BIT_DUTY_SELECT_LO = 5;
  localparam int BIT_DISPLAY_ENABLE = 4;
  localparam int BIT_WAVEFORM_TYPE = 2;
  localparam int BIT_FRAME_RATE_HI = 1;
  localparam int BIT_FRAME_RATE_LO = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hf7;
  localparam logic [7:0] ADDRESS_MASK = 8'h1f;
  localparam logic [7:0] DATA_MASK = 8'h0f;
  // system control fields
  localparam int BIT_PLL_SEL_HI = 6;
  localparam int BIT_PLL_SEL_LO = 4;
  localparam int BIT_IDLE = 3;
  localparam int BIT_BOOSTER_HI = 2;
  localparam int BIT_BOOSTER_LO = 1;
  localparam int BIT_CPU_CLOCK_SELECT = 0;
  localparam logic [7:0] SYS_CONTROL_MASK = 8'h7f;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RAM_ADDRESS = 8'h00;
  localparam logic [7:0] RST_SYS_CONTROL = 8'h00;
  // ---------------------------------------------------------------
  // sub-clock cycles per common slot, index = frame rate code
  // ---------------------------------------------------------------
  localparam logic [8:0] SLOT_HALF_0 = 9'h100; // 256
  localparam logic [8:0] SLOT_HALF_1 = 9'h118; // 280
  localparam logic [8:0] SLOT_HALF_2 = 9'h130; // 304
  localparam logic [8:0] SLOT_HALF_3 = 9'h0e8; // 232
  localparam logic [8:0] SLOT_THIRD_0 = 9'h0ac; // 172
  localparam logic [8:0] SLOT_THIRD_1 = 9'h0bc; // 188
  localparam logic [8:0] SLOT_THIRD_2 = 9'h0cc; // 204
  localparam logic [8:0] SLOT_THIRD_3 = 9'h09c; // 156
  localparam logic [8:0] SLOT_QUARTER_0 = 9'h080; // 128
  localparam logic [8:0] SLOT_QUARTER_1 = 9'h08c; // 140
  localparam logic [8:0] SLOT_QUARTER_2 = 9'h098; // 152
  localparam logic [8:0] SLOT_QUARTER_3 = 9'h074; // 116
  // pll multiplier times four: 130, 65, 65/2, 65/4, 244
  localparam logic [9:0] PLL_X4_0 = 10'h208;
  localparam logic [9:0] PLL_X4_1 = 10'h104;
  localparam logic [9:0] PLL_X4_2 = 10'h082;
  localparam logic [9:0] PLL_X4_3 = 10'h041;
  localparam logic [9:0] PLL_X4_HI = 10'h3d0;
  // drive rail codes: 0 ground, 1 low, 2 high, 3 top
  localparam logic [1:0] RAIL_GND = 2'h0;
  localparam logic [1:0] RAIL_LOW = 2'h1;
  localparam logic [1:0] RAIL_HIGH = 2'h2;
  localparam logic [1:0] RAIL_TOP = 2'h3;
endpackage : sld_pkg

// >>> rtl/sld_sync.sv
// two flip-flop synchroniser for one level
// assumes d arrives from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module sld_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta;
  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sld_sync
`default_nettype wire

// >>> rtl/sld_booster.sv
// charge-pump clock from the synchronised sub-clock
// assumes sub_rise pulses once per sub-clock period
`timescale 1ns/1ps
`default_nettype none
module sld_booster (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sub_level,
  input wire logic sub_rise,
  input wire logic [1:0] freq_sel,
  output logic pump_clk
);
  logic [3:0] div;
  logic next_pump;
  // free divider of sub-clock rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div <= 4'h0;
    else if (sub_rise) div <= div + 4'h1;
  end
  // pick full rate or divide by 4, 8, 16
  always_comb begin
    case (freq_sel)
      2'h0: next_pump = sub_level;
      2'h1: next_pump = div[1];
      2'h2: next_pump = div[2];
      2'h3: next_pump = div[3];
      default: next_pump = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pump_clk <= 1'b0;
    else pump_clk <= next_pump;
  end
endmodule : sld_booster
`default_nettype wire

// >>> verification/sld_driver_properties.sv
// checker for the segment display driver ports
// assumes a bind from the bench top onto sld_driver
`timescale 1ns/1ps
`default_nettype none
module sld_driver_properties #(
  parameter int NUM_SEG = 32,
  parameter int NUM_COM = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2*NUM_SEG-1:0] segment_out,
  input wire logic [2*NUM_COM-1:0] common_out,
  input wire logic [2:0] pll_mult_sel,
  input wire logic [9:0] pll_mult_x4
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------
  // helper state
  // ----------
  logic [7:0] ctl;
  logic rd;
  logic mid_rail;
  int n_sel;
  assign rd = pready && !pwrite;
  // shadow of the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
    end else if (pready && pwrite && paddr == 8'h00) begin
      ctl <= pwdata[7:0];
    end
  end
  // high rail use and count of fully driven commons
  always_comb begin
    mid_rail = 1'b0;
    n_sel = 0;
    for (int i = 0; i < NUM_SEG; i++) begin
      mid_rail |= segment_out[2*i +: 2] == 2'h2;
    end
    for (int i = 0; i < NUM_COM; i++) begin
      mid_rail |= common_out[2*i +: 2] == 2'h2;
      n_sel += (common_out[2*i +: 2] inside {2'h0, 2'h3}) ? 1 : 0;
    end
  end
  // ----------
  // properties
  // ----------
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too wide");
  property p_err_map;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c});
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");
  property p_addr_read;
    rd && paddr == 8'h04 |-> prdata[31:5] == 27'h0;
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("address high bits set");
  property p_data_read;
    rd && paddr == 8'h08 |-> prdata[31:4] == 28'h0;
  endproperty
  a_data_read: assert property (p_data_read) else $error("data high bits set");
  property p_ctl_read;
    rd && paddr == 8'h00 |-> prdata[31:8] == 24'h0 && !prdata[3];
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control unused bit set");
  property p_sys_read;
    rd && paddr == 8'h0c |-> prdata[31:7] == 25'h0;
  endproperty
  a_sys_read: assert property (p_sys_read) else $error("system bit 7 set");
  property p_pll;
    pll_mult_x4 == (pll_mult_sel[2] ? 10'h3d0 : 10'h208 >> pll_mult_sel[1:0]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll multiplier wrong");
  property p_off_ground;
    (!ctl[4]) [*4] |-> segment_out == '0 && common_out == '0;
  endproperty
  a_off_ground: assert property (p_off_ground) else $error("rails not ground");
  property p_half_bias;
    (ctl[4] && !ctl[7]) [*4] |-> !mid_rail;
  endproperty
  a_half_bias: assert property (p_half_bias) else $error("mid rail at half bias");
  property p_one_common;
    (ctl[4] && ctl[7] && ctl[6]) [*4] |-> n_sel == 1;
  endproperty
  a_one_common: assert property (p_one_common) else $error("not one common");
endmodule : sld_driver_properties
`default_nettype wire

// >>> verification/sld_glass.sv
// passive glass model: a dot shows when fully driven
// assumes rail codes 0..3 on the common and segment pins
`timescale 1ns/1ps
`default_nettype none
module sld_glass #(
  parameter int NUM_SEG = 32,
  parameter int NUM_COM = 4
) (
  input wire logic [2*NUM_SEG-1:0] segment_out,
  input wire logic [2*NUM_COM-1:0] common_out,
  output logic [NUM_SEG*NUM_COM-1:0] dot_on
);
  // dot 4*s+c lit when segment and common sit at opposite outer rails
  always_comb begin
    for (int s = 0; s < NUM_SEG; s++) begin
      for (int c = 0; c < NUM_COM; c++) begin
        dot_on[s*NUM_COM+c] = {segment_out[2*s +: 2], common_out[2*c +: 2]}
                              inside {4'h3, 4'hc};
      end
    end
  end
endmodule : sld_glass
`default_nettype wire

// >>> verification/sld_driver_tb.sv
// bench for sld_driver: register rows, scan timing, glass pattern
// assumes package, design, checker and glass model compiled first
`timescale 1ns/1ps
`default_nettype none
module sld_driver_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic e;
  } sld_row_s;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sub_clk = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pump_clk, idle_mode, cpu_clock_select, err;
  logic [63:0] segment_out;
  logic [7:0] common_out;
  logic [2:0] pll_mult_sel;
  logic [9:0] pll_mult_x4;
  logic [127:0] dot_on, seen, want;
  int n_fail = 0, total_checks = 0, cyc = 0, pump_n = 0, gap, e;
  int slot [3][4] = '{'{256, 280, 304, 232}, '{172, 188, 204, 156}, '{128, 140, 152, 116}};
  sld_row_s rows [6] = '{'{8'h00, 8'hff, 8'hf7, 1'b0}, '{8'h04, 8'hff, 8'h1f, 1'b0},
    '{8'h08, 8'hff, 8'h0f, 1'b0}, '{8'h0c, 8'hff, 8'h7f, 1'b0},
    '{8'h10, 8'hff, 8'h00, 1'b1}, '{8'h0c, 8'h00, 8'h00, 1'b0}};
  // clocks: pclk 10 ns, free-running sub-oscillator of six pclk
  always #5 pclk = ~pclk;
  always #30 sub_clk = ~sub_clk;
  always @(posedge pump_clk) pump_n++;
  sld_driver u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_clk(sub_clk), .segment_out(segment_out),
    .common_out(common_out), .pump_clk(pump_clk), .pll_mult_sel(pll_mult_sel),
    .pll_mult_x4(pll_mult_x4), .idle_mode(idle_mode), .cpu_clock_select(cpu_clock_select));
  sld_glass u_glass (.segment_out(segment_out), .common_out(common_out), .dot_on(dot_on));
  // ----------
  // tasks
  // ----------
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 20) begin
      @(posedge pclk);
      t++;
    end
    rd = prdata;
    err = pslverr;
    check(t < 20, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  // pclk edges until the common rails change
  task automatic edge_gap;
    logic [7:0] c0;
    c0 = common_out;
    gap = 0;
    while (common_out === c0 && gap < 4000) begin
      @(posedge pclk);
      gap++;
    end
  endtask : edge_gap
  // let a frame pass, then gather lit dots over one more
  task automatic watch;
    seen = '0;
    repeat (2800) @(posedge pclk);
    repeat (2800) begin
      @(posedge pclk);
      seen |= dot_on;
    end
  endtask : watch
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      test_done();
    end
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, 32'h0);
    end
    check({segment_out, common_out, pll_mult_x4}, {72'h0, 10'h208});
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, {24'hffffff, rows[i].d});
      apb(1'b0, rows[i].a, 32'h0);
      check({err, rd}, {rows[i].e, 24'h0, rows[i].q});
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 8'h0c, {25'h0, k[2:0], k[0], 2'b00, ~k[0]});
      settle();
      want = {k[2:0], k[0], ~k[0], k > 3 ? 10'h3d0 : 10'h208 >> k};
      check({pll_mult_sel, idle_mode, cpu_clock_select, pll_mult_x4}, want);
    end
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 8'h0c, {29'h0, f[1:0], 1'b0});
      settle();
      pump_n = 0;
      e = 32 >> (f > 0 ? f + 1 : 0);
      repeat (192) @(posedge pclk);
      check(pump_n >= e - 1 && pump_n <= e + 1, 1'b1);
    end
    for (int d = 0; d < 4; d++) begin
      for (int f = 0; f < 4; f++) begin
        apb(1'b1, 8'h00, {24'h0, d[0], d[1:0], 3'b101, f[1:0]});
        // first two gaps may be cut short by the config change
        edge_gap();
        edge_gap();
        edge_gap();
        check(gap, slot[d > 1 ? 2 : d][f] * 6);
      end
    end
    apb(1'b1, 8'h0c, 32'h8);
    apb(1'b1, 8'h00, 32'hd0);
    edge_gap();
    edge_gap();
    edge_gap();
    check(gap, 384);
    for (int s = 0; s < 32; s++) begin
      apb(1'b1, 8'h04, s);
      apb(1'b1, 8'h08, {28'h0, ~s[3:0]});
      want[4*s +: 4] = ~s[3:0];
    end
    apb(1'b1, 8'h00, 32'hd7);
    watch();
    check(seen, want);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'ha);
    want[12 +: 4] = 4'h0;
    watch();
    check(seen, want);
    // mid-run reset while the display runs
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({segment_out, common_out, pll_mult_x4}, {72'h0, 10'h208});
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    settle();
    check({segment_out, common_out}, 72'h0);
    test_done();
  end
endmodule : sld_driver_tb
bind sld_driver sld_driver_properties #(.NUM_SEG(NUM_SEG), .NUM_COM(NUM_COM)) u_props (
  .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .segment_out(segment_out),
  .common_out(common_out), .pll_mult_sel(pll_mult_sel), .pll_mult_x4(pll_mult_x4));
`default_nettype wire
